// ### bench/hcm_host_model.sv
// host processor model driving the backplane port of the mailbox
`timescale 1ns/1ns
module hcm_host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] din_in,
	input  wire logic       oe_in,
	output logic            wr_out,
	output logic            rd_out,
	output logic            addr_out,
	output logic [7:0]      wdata_out,
	output logic            ack_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 1'b0;
		wdata_out = 8'hA5;
		ack_out = 1'b0;
	end

	// k: 0 write, 1 read, 2 acknowledge; strobes held long enough for the pin filter
	task automatic acc(input logic [1:0] k, input logic a, input logic [7:0] d,
		output logic [7:0] q);
		addr_out <= a;
		wdata_out <= (k == 2'd0) ? d : ~wdata_out;
		wr_out <= (k == 2'd0);
		rd_out <= (k == 2'd1);
		ack_out <= (k == 2'd2);
		repeat (7) @(posedge clk_in);
		// undriven lines give the inverse, so a read without output enable fails
		q = oe_in ? din_in : ~din_in;
		wr_out <= 1'b0;
		rd_out <= 1'b0;
		ack_out <= 1'b0;
		// released bus shows the inverse byte, never a stale copy
		wdata_out <= ~wdata_out;
		repeat (5) @(posedge clk_in);
	endtask : acc
endmodule : hcm_host_model

// ### bench/tb.sv
// self-checking bench: ahb coprocessor side, host model, interrupt paths
`timescale 1ns/1ns
module tb import hcm_pkg::*;;
	logic        clk = 0;
	logic        rst_n = 0;
	logic        hsel = 0;
	logic [31:0] haddr = 0;
	logic [1:0]  htrans = 0;
	logic        hwrite = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] hrdata;
	logic        hready;
	logic        wr, rd, adr, ack, hint_n, irq, own, oe, hresp;
	logic [7:0]  hwb, din, vec, q, d;
	logic        scc = 0, sense_n = 1, cack = 0;
	logic [31:0] rs = 32'hF3870A97;
	int          mismatches = 0, compares = 0;
	// model of the mailbox flags
	logic        ca = 0, cm = 1, se = 1, fa = 0, te = 1, hp = 0;
	logic [3:0]  sw = 0;
	// bytes in flight through the mailbox, oldest first
	logic [7:0]  xq[$];

	always #2 clk = ~clk;

	hcm_mailbox dut (.ref_clk_in(clk), .reset_n_in(rst_n), .ce_in(1'b1), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
		.hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp), .host_wr_in(wr), .host_rd_in(rd), .host_addr_in(adr),
		.host_wdata_in(hwb), .host_ack_in(ack), .host_din_out(din), .host_din_oe_out(oe),
		.host_int_n_out(hint_n), .scc_irq_in(scc), .par_sense_n_in(sense_n),
		.cop_ack_in(cack), .cop_irq_out(irq), .cop_vec_out(vec), .cop_vec_own_out(own));

	hcm_host_model host (.clk_in(clk), .din_in(din), .oe_in(oe), .wr_out(wr),
		.rd_out(rd), .addr_out(adr), .wdata_out(hwb), .ack_out(ack));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
		return rs[7:0];
	endfunction : rnd

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic end_of_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test

	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done

	task automatic rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1) begin
			chk(8'h00, 8'h01);
			end_of_test();
		end
	endtask : rdy

	task automatic ahb(input logic w, input logic [2:0] i, input logic [7:0] v,
		output logic [7:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {27'h0, i, 2'h0};
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, v};
		rdy();
		r = hrdata[7:0];
		chk({7'h0, hresp}, 8'h00);
	endtask : ahb

	task automatic fl;
		ahb(1'b0, HCM_IDX_FLAG_CTL, 8'h00, q);
		chk(q, {te, fa, 2'b11, hp, 1'b1, se, ca});
	endtask : fl

	task automatic hs;
		host.acc(2'd1, 1'b0, 8'h00, q);
		chk(q, {~fa, ~te, sw, cm, 1'b1});
		se = 1'b1;
	endtask : hs

	task automatic cop_ack(input logic [7:0] e, input logic o);
		cack <= 1'b1;
		@(posedge clk);
		cack <= 1'b0;
		@(posedge clk);
		chk({7'h0, own}, {7'h0, o});
		if (o) chk(vec, e);
	endtask : cop_ack

	task automatic ctl(input logic [7:0] v);
		ahb(1'b1, HCM_IDX_FLAG_CTL, v, q);
	endtask : ctl

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		fl();
		hs();
		ahb(1'b1, 3'h4, 8'h5A, q);
		ahb(1'b0, 3'h4, 8'h00, q);
		chk(q, 8'h00);
		done("reset and unmapped");
		d = rnd();
		host.acc(2'd0, 1'b0, d, q);
		xq.push_back(d);
		cm = 0;
		ca = 1;
		fl();
		hs();
		ahb(1'b0, HCM_IDX_CMD_STAT, 8'h00, q);
		chk(q, xq.pop_front());
		fl();
		d = rnd();
		// hardware-owned bits get random values and must be ignored
		ahb(1'b1, HCM_IDX_CMD_STAT, d | 8'h02, q);
		sw = d[5:2];
		cm = 1;
		ca = 0;
		se = 0;
		fl();
		hs();
		fl();
		done("command and status");
		d = rnd();
		host.acc(2'd0, 1'b1, d, q);
		xq.push_back(d);
		fa = 1;
		fl();
		hs();
		ahb(1'b0, HCM_IDX_DATA, 8'h00, q);
		chk(q, xq.pop_front());
		fa = 0;
		fl();
		hs();
		d = rnd();
		ahb(1'b1, HCM_IDX_DATA, d, q);
		xq.push_back(d);
		te = 0;
		hs();
		host.acc(2'd1, 1'b1, 8'h00, q);
		chk(q, xq.pop_front());
		te = 1;
		fl();
		chk({7'h0, irq}, 8'h00);
		done("data both ways");
		ctl(8'h01);
		hs();
		chk({7'h0, irq}, 8'h01);
		cop_ack(HCM_VEC_HOST, 1'b1);
		chk({7'h0, irq}, 8'h00);
		// fresh host-access request while the serial controller is served
		hs();
		scc <= 1'b1;
		repeat (5) @(posedge clk);
		cop_ack(8'h00, 1'b0);
		scc <= 1'b0;
		repeat (5) @(posedge clk);
		chk({7'h0, irq}, 8'h01);
		cop_ack(HCM_VEC_HOST, 1'b1);
		chk({7'h0, irq}, 8'h00);
		ctl(8'h03);
		sense_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk({7'h0, irq}, 8'h01);
		cop_ack(HCM_VEC_PAR, 1'b1);
		chk({7'h0, irq}, 8'h00);
		sense_n <= 1'b1;
		repeat (5) @(posedge clk);
		hs();
		sense_n <= 1'b0;
		repeat (6) @(posedge clk);
		cop_ack(HCM_VEC_BOTH, 1'b1);
		chk({7'h0, irq}, 8'h00);
		fl();
		sense_n <= 1'b1;
		repeat (5) @(posedge clk);
		ctl(8'h01);
		sense_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk({7'h0, irq}, 8'h00);
		sense_n <= 1'b1;
		repeat (5) @(posedge clk);
		done("coprocessor interrupts");
		ahb(1'b1, HCM_IDX_HVEC, 8'h3C, q);
		repeat (4) @(posedge clk);
		chk({7'h0, hint_n}, 8'h01);
		fl();
		ctl(8'h04);
		d = rnd();
		ahb(1'b1, HCM_IDX_HVEC, d, q);
		repeat (3) @(posedge clk);
		chk({7'h0, hint_n}, 8'h00);
		hp = 1;
		fl();
		host.acc(2'd2, 1'b0, 8'h00, q);
		chk(q, d);
		chk({7'h0, hint_n}, 8'h01);
		hp = 0;
		fl();
		done("host interrupt");
		// a reset in mid-run must bring every flag and status bit back
		ahb(1'b1, HCM_IDX_DATA, rnd(), q);
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		sw = 4'h0;
		fl();
		hs();
		done("second reset");
		end_of_test();
	end
endmodule : tb

// ### design/hcm_mailbox.sv
// mailbox registers and interrupt logic between backplane host and coprocessor
//
// Overview of operation
// - serial controller request outranks parallel and host-access requests, which share lowest rank
// - parallel request acknowledged alone yields vector FAh and is withdrawn
// - host-access and parallel pending together at acknowledge yield combined vector F8h
// - acknowledged host-access request yields vector FCh
// - no parallel requests while parallel interrupt enable is clear
// - with coprocessor interrupts enabled, any host mailbox access raises a request
// - host-access requests fully suppressed while coprocessor interrupt enable is clear
// - vector write with host interrupts enabled drives backplane interrupt low
// - host acknowledge puts stored vector on data-in lines and releases request in the same cycle
// - vector writes are ignored while host interrupt enable is clear
// - each host command write sets command-available
// - writing one to command-empty sets it and clears command-available
// - status write keeps only D5..D2 and command-empty D1
// - host status read sets status-empty flag
// - coprocessor read of host data sets data-in-empty for the host
// - data-available flag is high while an unread host byte is held
// - host read of coprocessor data sets data-out-empty immediately
// - coprocessor write of host data sets data-out-available
`timescale 1ns/1ns
module hcm_mailbox
	import hcm_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        ce_in,
	// ahb-lite slave, coprocessor side
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// backplane host port
	input  wire logic        host_wr_in,
	input  wire logic        host_rd_in,
	input  wire logic        host_addr_in,
	input  wire logic [7:0]  host_wdata_in,
	input  wire logic        host_ack_in,
	output logic      [7:0]  host_din_out,
	output logic             host_din_oe_out,
	output logic             host_int_n_out,
	// coprocessor interrupt side
	input  wire logic        scc_irq_in,
	input  wire logic        par_sense_n_in,
	input  wire logic        cop_ack_in,
	output logic             cop_irq_out,
	output logic      [7:0]  cop_vec_out,
	output logic             cop_vec_own_out
);

	hcm_state_t st;
	hcm_state_t nx;

	logic        acc;
	logic        h_wr_ev;
	logic        h_rd_ev;
	logic        h_ack_ev;
	logic        h_adr;
	logic [7:0]  h_dat;
	logic        sense_ev;
	logic        scc_req;
	logic [7:0]  flags;
	logic [7:0]  hstat;

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		nx = st;
		acc = hsel_in && htrans_in[1] && hready_in;
		// the host status byte: D0 always reads 1 because reset holds the whole block
		hstat = {!st.dfh_avail, !st.dth_empty, st.sw_stat, st.cmd_empty, 1'b1};
		flags = {st.dth_empty, st.dfh_avail, 1'b1, 1'b1, st.hint_pend, 1'b1,
			st.stat_empty, st.cmd_avail};
		// a pin change counts once the second and third stages agree
		nx.s1 = {host_wdata_in, scc_irq_in, par_sense_n_in, host_ack_in, host_addr_in,
			host_rd_in, host_wr_in};
		nx.s2 = st.s1;
		nx.s3 = st.s2;
		nx.filt = (st.s2 & st.s3) | (st.filt & (st.s2 ^ st.s3));
		h_wr_ev  = nx.filt[HCM_SY_WR] && !st.filt[HCM_SY_WR];
		h_rd_ev  = nx.filt[HCM_SY_RD] && !st.filt[HCM_SY_RD];
		h_ack_ev = nx.filt[HCM_SY_ACK] && !st.filt[HCM_SY_ACK];
		sense_ev = !nx.filt[HCM_SY_SENSE] && st.filt[HCM_SY_SENSE];
		h_adr    = nx.filt[HCM_SY_ADR];
		h_dat    = nx.filt[HCM_SY_DAT +: 8];
		scc_req  = st.filt[HCM_SY_SCC];

		if (ce_in) begin
			// host acknowledge first, so a vector written in the same cycle re-arms
			if (h_ack_ev) begin
				nx.hint_pend = 1'b0;
			end

			// coprocessor acknowledge withdraws what it serves before new sets apply
			if (cop_ack_in) begin
				if (scc_req) begin
					nx.cop_vec_own = 1'b0;
				end else if (st.req_host && st.req_par) begin
					nx.cop_vec     = HCM_VEC_BOTH;
					nx.cop_vec_own = 1'b1;
					nx.req_host    = 1'b0;
					nx.req_par     = 1'b0;
				end else if (st.req_par) begin
					nx.cop_vec     = HCM_VEC_PAR;
					nx.cop_vec_own = 1'b1;
					nx.req_par     = 1'b0;
				end else if (st.req_host) begin
					nx.cop_vec     = HCM_VEC_HOST;
					nx.cop_vec_own = 1'b1;
					nx.req_host    = 1'b0;
				end else begin
					nx.cop_vec_own = 1'b0;
				end
			end

			// ahb data phase of a write
			if (st.ph == HCM_PH_WRITE && st.hit) begin
				if (st.idx == HCM_IDX_CMD_STAT) begin
					nx.sw_stat    = hwdata_in[HCM_ST_SW_HI:HCM_ST_SW_LO];
					nx.cmd_empty  = hwdata_in[HCM_ST_CMD_EMPTY];
					nx.stat_empty = 1'b0;
					if (hwdata_in[HCM_ST_CMD_EMPTY]) begin
						nx.cmd_avail = 1'b0;
					end
				end else if (st.idx == HCM_IDX_DATA) begin
					nx.dth       = hwdata_in[7:0];
					nx.dth_empty = 1'b0;
				end else if (st.idx == HCM_IDX_FLAG_CTL) begin
					nx.cop_en  = hwdata_in[HCM_CTL_COP_EN];
					nx.par_en  = hwdata_in[HCM_CTL_PAR_EN];
					nx.host_en = hwdata_in[HCM_CTL_HOST_EN];
				end else if (st.host_en) begin
					nx.hvec      = hwdata_in[7:0];
					nx.hint_pend = 1'b1;
				end
			end

			// read data is captured in the wait cycle, after any earlier write landed
			if (st.ph == HCM_PH_RDWAIT) begin
				if (!st.hit) begin
					nx.hrdata = 8'h00;
				end else if (st.idx == HCM_IDX_CMD_STAT) begin
					nx.hrdata = st.cmd;
				end else if (st.idx == HCM_IDX_DATA) begin
					nx.hrdata    = st.dfh;
					nx.dfh_avail = 1'b0;
				end else if (st.idx == HCM_IDX_FLAG_CTL) begin
					nx.hrdata = flags;
				end else begin
					nx.hrdata = 8'h00;
				end
			end

			// bus phase sequencing
			case (st.ph)
				HCM_PH_RDWAIT: begin
					nx.ph = HCM_PH_RDDONE;
				end
				default: begin
					if (acc) begin
						nx.ph = hwrite_in ? HCM_PH_WRITE : HCM_PH_RDWAIT;
						if (haddr_in[31:2] < 30'(HCM_NUM_REGS)) begin
							nx.hit = 1'b1;
							nx.idx = haddr_in[3:2];
						end else begin
							nx.hit = 1'b0;
							nx.idx = 2'h0;
						end
					end else begin
						nx.ph = HCM_PH_IDLE;
					end
				end
			endcase

			// host side events win over coprocessor clears in the same cycle
			if (h_wr_ev) begin
				if (!h_adr) begin
					nx.cmd       = h_dat;
					nx.cmd_avail = 1'b1;
					nx.cmd_empty = 1'b0;
				end else begin
					nx.dfh       = h_dat;
					nx.dfh_avail = 1'b1;
				end
			end
			if (h_rd_ev) begin
				if (!h_adr) begin
					nx.stat_empty = 1'b1;
				end else begin
					nx.dth_empty = 1'b1;
				end
			end
			if (h_wr_ev || h_rd_ev) begin
				nx.req_host = 1'b1;
			end
			if (sense_ev) begin
				nx.req_par = 1'b1;
			end
			if (!nx.cop_en) begin
				nx.req_host = 1'b0;
			end
			if (!nx.par_en) begin
				nx.req_par = 1'b0;
			end

			// backplane data-in lines: vector during acknowledge, else the addressed byte
			nx.host_din_oe = nx.filt[HCM_SY_ACK] || nx.filt[HCM_SY_RD];
			if (nx.filt[HCM_SY_ACK]) begin
				nx.host_din = st.hvec;
			end else if (!h_adr) begin
				nx.host_din = hstat;
			end else begin
				nx.host_din = st.dth;
			end
		end else begin
			// frozen: pin stages hold as well
			nx = st;
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= HCM_ST_RST;
		end else begin
			st <= nx;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign hrdata_out      = {24'h000000, st.hrdata};
	assign hreadyout_out   = (st.ph != HCM_PH_RDWAIT);
	assign hresp_out       = 1'b0;
	assign host_din_out    = st.host_din;
	assign host_din_oe_out = st.host_din_oe;
	assign host_int_n_out  = !st.hint_pend;
	// serial controller requests pass through the pin filter unlatched, outranking the rest
	assign cop_irq_out     = scc_req || st.req_par || st.req_host;
	assign cop_vec_out     = st.cop_vec;
	assign cop_vec_own_out = st.cop_vec_own;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in || !ce_in);

	sequence s_ack_idle_scc;
		ce_in && cop_ack_in && !scc_req;
	endsequence

	sequence s_rd_accept;
		ce_in && acc && !hwrite_in && st.ph != HCM_PH_RDWAIT;
	endsequence

	chk_vec_combined: assert property (
		s_ack_idle_scc and (st.req_host && st.req_par) |=> cop_vec_out == HCM_VEC_BOTH
	) else $error("combined vector not supplied");

	chk_vec_parallel: assert property (
		s_ack_idle_scc and (st.req_par && !st.req_host) |=> cop_vec_out == HCM_VEC_PAR
			&& cop_vec_own_out
	) else $error("parallel vector not supplied");

	chk_vec_host: assert property (
		s_ack_idle_scc and (st.req_host && !st.req_par && !h_wr_ev && !h_rd_ev)
			|=> cop_vec_out == HCM_VEC_HOST && !st.req_host
	) else $error("host-access vector not supplied or not withdrawn");

	chk_par_masked: assert property (
		!st.par_en |-> !st.req_par
	) else $error("parallel request while disabled");

	chk_host_masked: assert property (
		!st.cop_en |-> !st.req_host
	) else $error("host-access request while disabled");

	chk_access_raises: assert property (
		(h_wr_ev || h_rd_ev) && st.cop_en && st.ph != HCM_PH_WRITE |=> st.req_host
			&& cop_irq_out
	) else $error("host access raised no request");

	chk_hint_raise: assert property (
		st.ph == HCM_PH_WRITE && st.hit && st.idx == HCM_IDX_HVEC && st.host_en
			|=> !host_int_n_out && st.hvec == $past(hwdata_in[7:0])
	) else $error("vector write did not drive interrupt");

	chk_hvec_ignored: assert property (
		st.ph == HCM_PH_WRITE && st.idx == HCM_IDX_HVEC && !st.host_en && host_int_n_out
			|=> host_int_n_out
	) else $error("vector write raised request while disabled");

	chk_cmd_flags: assert property (
		h_wr_ev && !h_adr |=> st.cmd_avail && !st.cmd_empty
	) else $error("command write did not set available");

	chk_stat_read: assert property (
		h_rd_ev && !h_adr |=> st.stat_empty
	) else $error("status read did not set status-empty");

	chk_rd_wait: assert property (
		s_rd_accept |=> !hreadyout_out ##1 hreadyout_out
	) else $error("read data phase not one wait cycle");

	chk_scc_outranks: assert property (
		cop_ack_in && scc_req && st.req_host |=> !cop_vec_own_out
			&& (st.req_host || !st.cop_en)
	) else $error("serial request did not outrank host-access request");

	chk_hack_release: assert property (
		h_ack_ev && !(st.ph == HCM_PH_WRITE && st.idx == HCM_IDX_HVEC)
			|=> host_int_n_out && host_din_oe_out && host_din_out == $past(st.hvec)
	) else $error("host acknowledge did not present vector and release");

	chk_cmd_release: assert property (
		st.ph == HCM_PH_WRITE && st.hit && st.idx == HCM_IDX_CMD_STAT
			&& hwdata_in[HCM_ST_CMD_EMPTY] && !(h_wr_ev && !h_adr)
			|=> st.cmd_empty && !st.cmd_avail
	) else $error("command channel not reopened");

	chk_stat_bits: assert property (
		st.ph == HCM_PH_WRITE && st.hit && st.idx == HCM_IDX_CMD_STAT
			|=> st.sw_stat == $past(hwdata_in[HCM_ST_SW_HI:HCM_ST_SW_LO])
	) else $error("status write kept the wrong bits");

	chk_dfh_taken: assert property (
		st.ph == HCM_PH_RDWAIT && st.hit && st.idx == HCM_IDX_DATA && !h_wr_ev
			|=> !st.dfh_avail && hrdata_out[7:0] == $past(st.dfh)
	) else $error("host data read did not free the register");

	chk_dfh_held: assert property (
		h_wr_ev && h_adr |=> st.dfh_avail && st.dfh == $past(h_dat)
	) else $error("host data byte not flagged");

	chk_dth_flags: assert property (
		st.ph == HCM_PH_WRITE && st.hit && st.idx == HCM_IDX_DATA && !h_rd_ev
			|=> !st.dth_empty && st.dth == $past(hwdata_in[7:0])
	) else $error("coprocessor data write not flagged");

	chk_dth_read: assert property (
		h_rd_ev && h_adr |=> st.dth_empty
	) else $error("host data read did not set data-out-empty");

endmodule : hcm_mailbox

// ### design/hcm_pkg.sv
// package: register map, field positions, vectors and reset values of the mailbox
package hcm_pkg;

	// coprocessor-side register indices; byte address is four times the index
	localparam logic [1:0] HCM_IDX_CMD_STAT = 2'h0;
	localparam logic [1:0] HCM_IDX_DATA     = 2'h1;
	localparam logic [1:0] HCM_IDX_FLAG_CTL = 2'h2;
	localparam logic [1:0] HCM_IDX_HVEC     = 2'h3;
	localparam int         HCM_NUM_REGS     = 4;

	// control register bits
	localparam int HCM_CTL_COP_EN  = 0;
	localparam int HCM_CTL_PAR_EN  = 1;
	localparam int HCM_CTL_HOST_EN = 2;

	// host status byte fields
	localparam int HCM_ST_DFH_EMPTY = 7;
	localparam int HCM_ST_DTH_AVAIL = 6;
	localparam int HCM_ST_SW_HI     = 5;
	localparam int HCM_ST_SW_LO     = 2;
	localparam int HCM_ST_CMD_EMPTY = 1;
	localparam int HCM_ST_RESET_N   = 0;

	// fixed coprocessor vectors
	localparam logic [7:0] HCM_VEC_PAR  = 8'hFA;
	localparam logic [7:0] HCM_VEC_HOST = 8'hFC;
	localparam logic [7:0] HCM_VEC_BOTH = 8'hF8;

	// positions inside the synchronised pin vector
	localparam int         HCM_SY_WR    = 0;
	localparam int         HCM_SY_RD    = 1;
	localparam int         HCM_SY_ADR   = 2;
	localparam int         HCM_SY_ACK   = 3;
	localparam int         HCM_SY_SENSE = 4;
	localparam int         HCM_SY_SCC   = 5;
	localparam int         HCM_SY_DAT   = 6;
	localparam int         HCM_SY_W     = 14;
	localparam logic [13:0] HCM_SY_RST  = 14'h0010;

	typedef enum logic [3:0] {
		HCM_PH_IDLE   = 4'h1,
		HCM_PH_WRITE  = 4'h2,
		HCM_PH_RDWAIT = 4'h4,
		HCM_PH_RDDONE = 4'h8
	} hcm_phase_t;

	typedef struct packed {
		hcm_phase_t  ph;
		logic [1:0]  idx;
		logic        hit;
		logic [7:0]  hrdata;
		logic        cop_en;
		logic        par_en;
		logic        host_en;
		logic [7:0]  cmd;
		logic        cmd_avail;
		logic        cmd_empty;
		logic [3:0]  sw_stat;
		logic        stat_empty;
		logic [7:0]  dfh;
		logic        dfh_avail;
		logic [7:0]  dth;
		logic        dth_empty;
		logic [7:0]  hvec;
		logic        hint_pend;
		logic        req_par;
		logic        req_host;
		logic [7:0]  cop_vec;
		logic        cop_vec_own;
		logic [13:0] s1;
		logic [13:0] s2;
		logic [13:0] s3;
		logic [13:0] filt;
		logic [7:0]  host_din;
		logic        host_din_oe;
	} hcm_state_t;

	localparam hcm_state_t HCM_ST_RST = '{
		ph: HCM_PH_IDLE, idx: 2'h0, hit: 1'b0, hrdata: 8'h00,
		cop_en: 1'b0, par_en: 1'b0, host_en: 1'b0,
		cmd: 8'h00, cmd_avail: 1'b0, cmd_empty: 1'b1, sw_stat: 4'h0, stat_empty: 1'b1,
		dfh: 8'h00, dfh_avail: 1'b0, dth: 8'h00, dth_empty: 1'b1,
		hvec: 8'h00, hint_pend: 1'b0, req_par: 1'b0, req_host: 1'b0,
		cop_vec: 8'h00, cop_vec_own: 1'b0,
		s1: HCM_SY_RST, s2: HCM_SY_RST, s3: HCM_SY_RST, filt: HCM_SY_RST,
		host_din: 8'h00, host_din_oe: 1'b0
	};

endpackage : hcm_pkg
